// *** erb_ram_block.sv ***
// Configurable embedded RAM block, small or large kind chosen by parameter.
// Assumes fabric logic on ref_clk drives every port and holds config static while used.
//
// Summary of operation
// - Small block stores 576 bits including parity bits.
// - Small block runs as simple dual-port, single-port, FIFO, ROM or shift register.
// - Small block contents preload from an init image when used as RAM or ROM.
// - Small block shapes are 512x1 to 32x16, plus 64x9 and 32x18.
// - Small x1/x2 reads take any plain write width; x4 reads take x1, x2, x4, x16.
// - Small x8 reads take x1, x2, x8; x16 take x1-x4, x16; parity shapes self-pair.
// - Shift register mode holds at most 576 bits.
// - Mixed read and write widths let the block serialize or deserialize.
// - Large block stores 589,824 bits including parity bits.
// - Large block runs as true dual-port, simple dual-port, single-port or FIFO.
// - Large block has no init contents; user writes before trusting reads.
// - Port inputs and the mode are registered, while shapes, parity, cfgOutReg and shiftDepth act directly; the output register may be used or bypassed.
// - Large block shapes are 64Kx8/9 down to 4Kx128/144.
// - Large block refuses the 4K-deep widest shape in true dual-port mode.
// - Large 9 to 72 bit shapes pair freely; 144 bit shape pairs only with itself.
`timescale 1ns/1ps
`include "erb_defs.svh"

module erb_ram_block #(
    parameter bit                          LARGE      = 1'b0,
    parameter int                          AW         = LARGE ? `ERB_LARGE_AW : `ERB_SMALL_AW,
    parameter int                          MW         = LARGE ? `ERB_LARGE_MAXW : `ERB_SMALL_MAXW,
    parameter logic [`ERB_SMALL_BITS-1:0]  INIT_IMAGE = '0
) (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire erb_pkg::erb_mode_t  cfgMode,
    input  wire logic [2:0]          cfgWrShape,
    input  wire logic [2:0]          cfgRdShape,
    input  wire logic                cfgParity,
    input  wire logic                cfgOutReg,
    input  wire logic [AW:0]         shiftDepth,
    input  wire logic                aEn,
    input  wire logic                aWe,
    input  wire logic [AW-1:0]       aAddr,
    input  wire logic [MW-1:0]       aWrData,
    output logic      [MW-1:0]       aRdData,
    input  wire logic                bEn,
    input  wire logic                bWe,
    input  wire logic [AW-1:0]       bAddr,
    input  wire logic [MW-1:0]       bWrData,
    output logic      [MW-1:0]       bRdData,
    output logic                     fifoFull,
    output logic                     fifoEmpty,
    output logic                     cfgError
);
    localparam int BITS = LARGE ? `ERB_LARGE_BITS : `ERB_SMALL_BITS;

    typedef struct packed {
        erb_pkg::erb_mode_t mode;
        logic               err;
        logic               aEn;
        logic               aWe;
        logic [AW-1:0]      aAddr;
        logic [MW-1:0]      aDin;
        logic               bEn;
        logic               bWe;
        logic [AW-1:0]      bAddr;
        logic [MW-1:0]      bDin;
        logic [MW-1:0]      aQ;
        logic [MW-1:0]      bQ;
        logic [MW-1:0]      aOut;
        logic [MW-1:0]      bOut;
        logic [AW:0]        wp;
        logic [AW:0]        rp;
        logic [AW:0]        cnt;
        logic [AW:0]        shPtr;
    } erb_state_t;

    erb_state_t st_r;
    erb_state_t st_nxt;
    logic       mem [BITS];

    function automatic int unsigned shapeW(input logic [2:0] s, input logic par);
        if (LARGE) begin
            shapeW = (par ? `ERB_LANE_PAR : `ERB_LANE) << s;
        end else if (s == `ERB_SHAPE_X9) begin
            shapeW = `ERB_LANE_PAR;
        end else if (s == `ERB_SHAPE_X18) begin
            shapeW = 2 * `ERB_LANE_PAR;
        end else begin
            shapeW = 1 << s;
        end
    endfunction

    function automatic int unsigned shapeD(input logic [2:0] s);
        if (LARGE) begin
            shapeD = `ERB_LARGE_DEPTH >> s;
        end else if (s == `ERB_SHAPE_X9) begin
            shapeD = `ERB_SMALL_DEPTH >> `ERB_X9_SHIFT;
        end else if (s == `ERB_SHAPE_X18) begin
            shapeD = `ERB_SMALL_DEPTH >> `ERB_X18_SHIFT;
        end else begin
            shapeD = `ERB_SMALL_DEPTH >> s;
        end
    endfunction

    // Plain large shapes skip the ninth bit of each lane, so x8 and x9 views share a word map.
    function automatic int unsigned bitIdx(input int unsigned addr, input int unsigned w,
                                           input logic lane, input int unsigned i);
        if (lane) begin
            bitIdx = addr * (w / `ERB_LANE * `ERB_LANE_PAR)
                   + (i / `ERB_LANE) * `ERB_LANE_PAR + i % `ERB_LANE;
        end else begin
            bitIdx = addr * w + i;
        end
    endfunction

    function automatic logic pairOk(input logic [2:0] rd, input logic [2:0] wr);
        logic [6:0] mask;
        mask = '0;
        if (LARGE) begin
            pairOk = rd <= `ERB_SHAPE_WIDEST && wr <= `ERB_SHAPE_WIDEST
                  && ((rd == `ERB_SHAPE_WIDEST) == (wr == `ERB_SHAPE_WIDEST));
        end else begin
            case (rd)
                3'h0:    mask = `ERB_PAIR_X1;
                3'h1:    mask = `ERB_PAIR_X2;
                3'h2:    mask = `ERB_PAIR_X4;
                3'h3:    mask = `ERB_PAIR_X8;
                3'h4:    mask = `ERB_PAIR_X16;
                3'h5:    mask = `ERB_PAIR_X9;
                3'h6:    mask = `ERB_PAIR_X18;
                default: mask = '0;
            endcase
            pairOk = wr < 3'h7 && mask[wr];
        end
    endfunction

    function automatic logic [AW:0] wrapInc(input logic [AW:0] p, input int unsigned lim);
        wrapInc = (32'(p) + 1 >= lim) ? '0 : p + 1'b1;
    endfunction

    int unsigned wA;
    int unsigned wB;
    int unsigned dA;
    int unsigned capBits;
    int unsigned usedA;
    logic        lane;
    logic        modeOk;
    logic        dual;
    logic        errNow;

    always_comb begin
        wA      = shapeW(cfgWrShape, cfgParity);
        wB      = shapeW(cfgRdShape, cfgParity);
        dA      = shapeD(cfgWrShape);
        lane    = LARGE && !cfgParity;
        capBits = 32'(shiftDepth) * wA;
        usedA   = lane ? dA * (wA / `ERB_LANE * `ERB_LANE_PAR) : dA * wA;
        dual    = cfgMode == erb_pkg::ERB_SDP || cfgMode == erb_pkg::ERB_TDP
               || cfgMode == erb_pkg::ERB_FIFO;
        if (LARGE) begin
            modeOk = cfgMode inside {erb_pkg::ERB_TDP, erb_pkg::ERB_SDP,
                                     erb_pkg::ERB_SP, erb_pkg::ERB_FIFO};
        end else begin
            modeOk = cfgMode <= erb_pkg::ERB_SHIFT;
        end
        errNow = !modeOk
              || !pairOk(cfgWrShape, cfgWrShape) || !pairOk(cfgRdShape, cfgRdShape)
              || (dual && !pairOk(cfgRdShape, cfgWrShape))
              || (cfgMode == erb_pkg::ERB_TDP && (cfgWrShape == `ERB_SHAPE_WIDEST
                  || cfgRdShape == `ERB_SHAPE_WIDEST))
              || (cfgMode == erb_pkg::ERB_FIFO && cfgWrShape != cfgRdShape)
              || (cfgMode == erb_pkg::ERB_SHIFT && (shiftDepth == '0 || capBits > BITS));
    end

    // Operations act one cycle after the request, from the captured copy of the inputs.
    logic        weA;
    logic        weB;
    logic        rdA;
    logic        rdB;
    logic        pushOk;
    logic        popOk;
    int unsigned addrA;
    int unsigned addrB;
    logic [MW-1:0] qA;
    logic [MW-1:0] qB;

    always_comb begin
        weA    = 1'b0;
        weB    = 1'b0;
        rdA    = 1'b0;
        rdB    = 1'b0;
        addrA  = 32'(st_r.aAddr) % dA;
        addrB  = 32'(st_r.bAddr) % shapeD(cfgRdShape);
        pushOk = st_r.aEn && st_r.aWe && 32'(st_r.cnt) < dA;
        popOk  = st_r.bEn && st_r.cnt != '0;
        case (st_r.mode)
            erb_pkg::ERB_SDP: begin
                weA = st_r.aEn && st_r.aWe;
                rdB = st_r.bEn;
            end
            erb_pkg::ERB_SP: begin
                weA = st_r.aEn && st_r.aWe;
                rdA = st_r.aEn;
            end
            erb_pkg::ERB_FIFO: begin
                weA   = pushOk;
                rdB   = popOk;
                addrA = 32'(st_r.wp);
                addrB = 32'(st_r.rp);
            end
            erb_pkg::ERB_ROM: begin
                rdB = st_r.bEn;
            end
            erb_pkg::ERB_SHIFT: begin
                weA   = st_r.aEn;
                rdA   = st_r.aEn;
                addrA = 32'(st_r.shPtr);
            end
            erb_pkg::ERB_TDP: begin
                weA = st_r.aEn && st_r.aWe;
                rdA = st_r.aEn;
                weB = st_r.bEn && st_r.bWe;
                rdB = st_r.bEn;
            end
            default: begin
                weA = 1'b0;
            end
        endcase
        if (st_r.err) begin
            weA = 1'b0;
            weB = 1'b0;
            rdA = 1'b0;
            rdB = 1'b0;
        end
        qA = '0;
        qB = '0;
        for (int i = 0; i < MW; i++) begin
            if (i < wA && bitIdx(addrA, wA, lane, i) < BITS) begin
                qA[i] = mem[bitIdx(addrA, wA, lane, i)];
            end
            if (i < wB && bitIdx(addrB, wB, lane, i) < BITS) begin
                qB[i] = mem[bitIdx(addrB, wB, lane, i)];
            end
        end
    end

    always_comb begin
        st_nxt       = st_r;
        st_nxt.mode  = cfgMode;
        st_nxt.err   = errNow;
        st_nxt.aEn   = aEn;
        st_nxt.aWe   = aWe;
        st_nxt.aAddr = aAddr;
        st_nxt.aDin  = aWrData;
        st_nxt.bEn   = bEn;
        st_nxt.bWe   = bWe;
        st_nxt.bAddr = bAddr;
        st_nxt.bDin  = bWrData;
        st_nxt.aQ    = rdA ? qA : st_r.aQ;
        st_nxt.bQ    = rdB ? qB : st_r.bQ;
        st_nxt.aOut  = st_r.aQ;
        st_nxt.bOut  = st_r.bQ;
        if (!st_r.err && st_r.mode == erb_pkg::ERB_FIFO) begin
            if (pushOk) begin
                st_nxt.wp = wrapInc(st_r.wp, dA);
            end
            if (popOk) begin
                st_nxt.rp = wrapInc(st_r.rp, dA);
            end
            st_nxt.cnt = st_r.cnt + (AW + 1)'(pushOk) - (AW + 1)'(popOk);
        end
        if (weA && st_r.mode == erb_pkg::ERB_SHIFT) begin
            st_nxt.shPtr = wrapInc(st_r.shPtr, 32'(shiftDepth));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // The large kind is never cleared or loaded, matching its undefined power-up contents.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            if (!LARGE) begin
                for (int i = 0; i < `ERB_SMALL_BITS; i++) begin
                    mem[i] <= INIT_IMAGE[i];
                end
            end
        end else begin
            for (int i = 0; i < MW; i++) begin
                if (weA && i < wA && bitIdx(addrA, wA, lane, i) < BITS) begin
                    mem[bitIdx(addrA, wA, lane, i)] <= st_r.aDin[i];
                end
                if (weB && i < wB && bitIdx(addrB, wB, lane, i) < BITS) begin
                    mem[bitIdx(addrB, wB, lane, i)] <= st_r.bDin[i];
                end
            end
        end
    end

    // The bypass saves a cycle of latency at the cost of a longer output path.
    assign aRdData   = cfgOutReg ? st_r.aOut : st_r.aQ;
    assign bRdData   = cfgOutReg ? st_r.bOut : st_r.bQ;
    assign fifoFull  = 32'(st_r.cnt) >= dA;
    assign fifoEmpty = st_r.cnt == '0;
    assign cfgError  = st_r.err;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_spWrite;
        st_r.mode == erb_pkg::ERB_SP && weA;
    endsequence
    sequence s_spReadSame;
        rdA && !weA && st_r.aAddr == $past(st_r.aAddr) && $stable(cfgWrShape);
    endsequence

    a_capacity_fit: assert property (!errNow |-> usedA <= BITS)
        else $error("shape exceeds block capacity");
    a_small_shapes: assert property (!LARGE && !errNow |-> usedA == `ERB_SMALL_DEPTH
                                     || usedA == `ERB_SMALL_BITS)
        else $error("small shape does not fill the array");
    a_x4_x8_reject: assert property (!LARGE && cfgMode == erb_pkg::ERB_SDP
                                     && cfgRdShape == 3'h2 && cfgWrShape == 3'h3 |=> cfgError)
        else $error("x4 read with x8 write accepted");
    a_x8_x4_reject: assert property (!LARGE && cfgMode == erb_pkg::ERB_SDP
                                     && cfgRdShape == 3'h3 && cfgWrShape == 3'h2 |=> cfgError)
        else $error("x8 read with x4 write accepted");
    a_shift_cap: assert property (cfgMode == erb_pkg::ERB_SHIFT && capBits > BITS
                                  |=> cfgError)
        else $error("oversized shift register accepted");
    a_large_modes: assert property (LARGE && cfgMode inside {erb_pkg::ERB_ROM,
                                    erb_pkg::ERB_SHIFT} |=> cfgError)
        else $error("large block accepted a small-only mode");
    a_tdp_widest: assert property (LARGE && cfgMode == erb_pkg::ERB_TDP
                                   && cfgWrShape == `ERB_SHAPE_WIDEST |=> cfgError)
        else $error("widest shape accepted in true dual-port mode");
    a_large_pairs: assert property (LARGE && cfgMode == erb_pkg::ERB_SDP
                                    && cfgRdShape < 3'h4 && cfgWrShape < 3'h4 |=> !cfgError)
        else $error("legal large pairing refused");
    a_rom_readonly: assert property (st_r.mode == erb_pkg::ERB_ROM |-> !weA && !weB)
        else $error("write reached memory in ROM mode");
    a_sp_readback: assert property (s_spWrite ##1 s_spReadSame
                                    |=> st_r.aQ[0] == $past(st_r.aDin[0], 2))
        else $error("single-port read did not return written data");
    a_fifo_full_hold: assert property (st_r.mode == erb_pkg::ERB_FIFO && fifoFull
                                       && !popOk |=> st_r.cnt == $past(st_r.cnt))
        else $error("FIFO count moved while full");
    a_out_register: assert property (rdA ##1 (!rdA && cfgOutReg)
                                     |=> aRdData == $past(qA, 2))
        else $error("output register did not delay read data by one cycle");
endmodule

// *** erb_defs.svh ***
// Constants for the embedded RAM block: capacities, shapes and pairing masks.
// Assumes it is included by bare name from the design module.
`ifndef ERB_DEFS_SVH
`define ERB_DEFS_SVH
`define ERB_SMALL_BITS   576
`define ERB_LARGE_BITS   589824
`define ERB_SMALL_DEPTH  512
`define ERB_LARGE_DEPTH  65536
`define ERB_SMALL_AW     9
`define ERB_LARGE_AW     16
`define ERB_SMALL_MAXW   18
`define ERB_LARGE_MAXW   144
`define ERB_LANE         8
`define ERB_LANE_PAR     9
`define ERB_SHAPE_X9     3'h5
`define ERB_SHAPE_X18    3'h6
`define ERB_SHAPE_WIDEST 3'h4
`define ERB_X9_SHIFT     3
`define ERB_X18_SHIFT    4
`define ERB_PAIR_X1      7'h1f
`define ERB_PAIR_X2      7'h1f
`define ERB_PAIR_X4      7'h17
`define ERB_PAIR_X8      7'h0b
`define ERB_PAIR_X16     7'h17
`define ERB_PAIR_X9      7'h20
`define ERB_PAIR_X18     7'h40
`endif

// *** erb_pkg.sv ***
// Types shared by the embedded RAM block.
// Assumes erb_defs.svh is on the include path.
package erb_pkg;
    typedef enum logic [2:0] {
        ERB_SDP   = 3'b000,
        ERB_SP    = 3'b001,
        ERB_FIFO  = 3'b010,
        ERB_ROM   = 3'b011,
        ERB_SHIFT = 3'b100,
        ERB_TDP   = 3'b101
    } erb_mode_t;
endpackage

// *** erb_fabric_model.sv ***
// Fabric-side user logic that drives both ports of the embedded RAM block.
// Assumes a single ref_clk; requests change only at falling edges.
`timescale 1ns/1ps

module erb_fabric_model #(
    parameter int AW = 9,
    parameter int MW = 18
) (
    input  wire logic          ref_clk,
    output logic               aEn,
    output logic               aWe,
    output logic      [AW-1:0] aAddr,
    output logic      [MW-1:0] aWrData,
    output logic               bEn,
    output logic               bWe,
    output logic      [AW-1:0] bAddr,
    output logic      [MW-1:0] bWrData
);
    initial begin
        aEn = 1'b0;
        aWe = 1'b0;
        aAddr = '0;
        aWrData = '0;
        bEn = 1'b0;
        bWe = 1'b0;
        bAddr = '0;
        bWrData = '0;
    end

    // Address and data of a disabled port flip instead of holding, so a stale value is never read as valid.
    task automatic cyc(input logic ae, input logic aw, input logic [AW-1:0] aa,
                       input logic [MW-1:0] ad, input logic be, input logic bw,
                       input logic [AW-1:0] ba, input logic [MW-1:0] bd);
        @(negedge ref_clk);
        aEn = ae;
        aWe = aw;
        aAddr = ae ? aa : ~aAddr;
        aWrData = ae ? ad : ~aWrData;
        bEn = be;
        bWe = bw;
        bAddr = be ? ba : ~bAddr;
        bWrData = be ? bd : ~bWrData;
    endtask

    task automatic idle(input int n);
        repeat (n) cyc(1'b0, 1'b0, '0, '0, 1'b0, 1'b0, '0, '0);
    endtask
endmodule

// *** embedded_ram_blocks_test.sv ***
// Self-checking bench for the small embedded RAM block.
// Assumes the design and the fabric model compile before this file.
`timescale 1ns/1ps

module embedded_ram_blocks_test;
    localparam logic [575:0] IMAGE = {36{16'ha5c3}};
    logic               ref_clk = 1'b0;
    logic               rst = 1'b1;
    erb_pkg::erb_mode_t cfgMode = erb_pkg::ERB_ROM;
    logic [2:0]         cfgWrShape = 3'h4;
    logic [2:0]         cfgRdShape = 3'h4;
    logic               cfgParity = 1'b0;
    logic               cfgOutReg = 1'b0;
    logic [9:0]         shiftDepth = 10'h004;
    logic               aEn, aWe, bEn, bWe, fifoFull, fifoEmpty, cfgError;
    logic [8:0]         aAddr, bAddr;
    logic [17:0]        aWrData, bWrData, aRdData, bRdData;
    int                 numErrors = 0;
    int                 comparisons = 0;
    // Legal write shapes per read shape, one bit per write shape.
    logic [6:0]         pairOk [7] = '{7'h1f, 7'h1f, 7'h17, 7'h0b, 7'h17, 7'h20, 7'h40};

    always #2.5 ref_clk = ~ref_clk;

    erb_ram_block #(.LARGE(1'b0), .INIT_IMAGE(IMAGE)) erb_ram_block_i (
        .ref_clk(ref_clk), .rst(rst), .cfgMode(cfgMode), .cfgWrShape(cfgWrShape),
        .cfgRdShape(cfgRdShape), .cfgParity(cfgParity), .cfgOutReg(cfgOutReg),
        .shiftDepth(shiftDepth), .aEn(aEn), .aWe(aWe), .aAddr(aAddr), .aWrData(aWrData),
        .aRdData(aRdData), .bEn(bEn), .bWe(bWe), .bAddr(bAddr), .bWrData(bWrData),
        .bRdData(bRdData), .fifoFull(fifoFull), .fifoEmpty(fifoEmpty), .cfgError(cfgError));

    erb_fabric_model #(.AW(9), .MW(18)) erb_fabric_model_i (
        .ref_clk(ref_clk), .aEn(aEn), .aWe(aWe), .aAddr(aAddr), .aWrData(aWrData),
        .bEn(bEn), .bWe(bWe), .bAddr(bAddr), .bWrData(bWrData));

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        comparisons++;
        if (seen !== exp) begin
            numErrors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        if (numErrors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Config changes only while both ports idle, as the block expects.
    task automatic setCfg(input erb_pkg::erb_mode_t m, input logic [2:0] w,
                          input logic [2:0] r, input logic o, input logic [9:0] d);
        erb_fabric_model_i.idle(1);
        cfgMode = m;
        cfgWrShape = w;
        cfgRdShape = r;
        cfgOutReg = o;
        shiftDepth = d;
        erb_fabric_model_i.idle(3);
    endtask

    task automatic rd(input logic port, input logic [8:0] ad, output logic [17:0] seen);
        erb_fabric_model_i.cyc(!port, 1'b0, ad, '0, port, 1'b0, ad, '0);
        erb_fabric_model_i.idle(2 + int'(cfgOutReg));
        seen = port ? bRdData : aRdData;
    endtask

    task automatic wrA(input logic [8:0] ad, input logic [17:0] d);
        erb_fabric_model_i.cyc(1'b1, 1'b1, ad, d, 1'b0, 1'b0, '0, '0);
    endtask

    task automatic romCase;
        logic [17:0] s;
        rd(1'b1, 9'h001, s);
        check(s[15:0], 16'ha5c3);
        wrA(9'h001, 18'h00000);
        rd(1'b1, 9'h001, s);
        check(s[15:0], 16'ha5c3);
    endtask

    task automatic pairCase;
        for (int r = 0; r < 7; r++) begin
            for (int w = 0; w < 7; w++) begin
                setCfg(erb_pkg::ERB_SDP, 3'(w), 3'(r), 1'b0, 10'h004);
                check(cfgError, !pairOk[r][w]);
            end
        end
        setCfg(erb_pkg::ERB_SDP, 3'h7, 3'h7, 1'b0, 10'h004);
        check(cfgError, 1'b1);
    endtask

    task automatic modeCase;
        for (int m = 0; m < 6; m++) begin
            setCfg(erb_pkg::erb_mode_t'(m), 3'h4, 3'h4, 1'b0, 10'h004);
            check(cfgError, m == 5);
        end
    endtask

    task automatic sdpCase;
        logic [17:0] s;
        setCfg(erb_pkg::ERB_SDP, 3'h4, 3'h0, 1'b0, 10'h004);
        wrA(9'h003, 18'h08001);
        rd(1'b1, 9'd48, s);
        check(s[0], 1'b1);
        rd(1'b1, 9'd49, s);
        check(s[0], 1'b0);
        rd(1'b1, 9'd63, s);
        check(s[0], 1'b1);
        // A read that meets a write to the same bit returns the old value.
        erb_fabric_model_i.cyc(1'b1, 1'b1, 9'h003, '0, 1'b1, 1'b0, 9'd48, '0);
        erb_fabric_model_i.idle(2);
        check(bRdData[0], 1'b1);
        rd(1'b1, 9'd48, s);
        check(s[0], 1'b0);
        setCfg(erb_pkg::ERB_SDP, 3'h4, 3'h4, 1'b1, 10'h004);
        wrA(9'h005, 18'h01234);
        rd(1'b1, 9'h003, s);
        check(s[15:0], 16'h0000);
        erb_fabric_model_i.cyc(1'b0, 1'b0, '0, '0, 1'b1, 1'b0, 9'h005, '0);
        erb_fabric_model_i.idle(2);
        check(bRdData[15:0], 16'h0000);
        erb_fabric_model_i.idle(1);
        check(bRdData[15:0], 16'h1234);
    endtask

    // Port A readback in single-port mode, bypassed and registered, with the parity
    // select toggled (the small kind ignores it), then a port B write refused in SDP.
    task automatic spCase;
        logic [17:0] s;
        setCfg(erb_pkg::ERB_SP, 3'h4, 3'h4, 1'b0, 10'h004);
        cfgParity = 1'b1;
        wrA(9'h002, 18'h0beef);
        rd(1'b0, 9'h002, s);
        check(s[15:0], 16'hbeef);
        setCfg(erb_pkg::ERB_SP, 3'h4, 3'h4, 1'b1, 10'h004);
        rd(1'b0, 9'h002, s);
        check(s[15:0], 16'hbeef);
        setCfg(erb_pkg::ERB_SDP, 3'h4, 3'h4, 1'b0, 10'h004);
        erb_fabric_model_i.cyc(1'b0, 1'b0, '0, '0, 1'b1, 1'b1, 9'h002, 18'h01111);
        erb_fabric_model_i.idle(2);
        rd(1'b1, 9'h002, s);
        check(s[15:0], 16'hbeef);
        cfgParity = 1'b0;
    endtask

    task automatic shiftCase;
        setCfg(erb_pkg::ERB_SHIFT, 3'h4, 3'h4, 1'b0, 10'd36);
        check(cfgError, 1'b0);
        setCfg(erb_pkg::ERB_SHIFT, 3'h4, 3'h4, 1'b0, 10'd37);
        check(cfgError, 1'b1);
        setCfg(erb_pkg::ERB_SHIFT, 3'h4, 3'h4, 1'b0, 10'd4);
        for (int k = 1; k <= 10; k++) begin
            wrA(9'h000, 18'(k));
            erb_fabric_model_i.idle(2);
            if (k > 4) check(aRdData[15:0], 16'(k - 4));
        end
    endtask

    task automatic fifoCase;
        setCfg(erb_pkg::ERB_FIFO, 3'h3, 3'h3, 1'b0, 10'h004);
        check(fifoEmpty, 1'b1);
        for (int k = 0; k < 64; k++) begin
            wrA(9'h000, 18'(k));
        end
        erb_fabric_model_i.idle(3);
        check({fifoFull, fifoEmpty}, 2'b10);
        wrA(9'h000, 18'h000ff);
        erb_fabric_model_i.idle(3);
        for (int k = 0; k < 64; k++) begin
            erb_fabric_model_i.cyc(1'b0, 1'b0, '0, '0, 1'b1, 1'b0, '0, '0);
            erb_fabric_model_i.idle(2);
            check(bRdData[7:0], 8'(k));
        end
        erb_fabric_model_i.idle(1);
        check({fifoFull, fifoEmpty}, 2'b01);
        erb_fabric_model_i.cyc(1'b0, 1'b0, '0, '0, 1'b1, 1'b0, '0, '0);
        erb_fabric_model_i.idle(2);
        check(bRdData[7:0], 8'd63);
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        check(aRdData, 18'h0);
        check(bRdData, 18'h0);
        check({fifoEmpty, fifoFull}, 2'b10);
        romCase();
        pairCase();
        modeCase();
        sdpCase();
        spCase();
        shiftCase();
        fifoCase();
        conclude();
    end

    // A hang anywhere counts as a failure and still reaches the report.
    initial begin
        repeat (20000) @(posedge ref_clk);
        numErrors++;
        conclude();
    end
endmodule
